/* File: core/scc_regs.sv */
// Synthesizer setup and receive/transmit control registers.
// Assumes a serial front end hands over whole 24-bit words with a one-cycle
// strobe on clk; the shift and latch protocol lives outside this block.
//
// How it works
// - address five word loads synthesizer register
// - bit 23 picks UHF input, gated
// - bit 17 enables fractional-N compensation
// - bit 14 doubler, only in 1900 mode
// - bits 8:7 choose denominator 5/8/13/20
// - bits 5:4 set UHF pump current
// - bit 22 picks receive injection side
// - bit 21 receive LO divide two/four
// - bit 20 receive phase detector polarity
// - bits 19:18 receive VHF pump current
// - bit 15 enables transmit DLL
// - bit 13 picks transmit injection side
// - bit 12 transmit LO divide two/four
// - bit 11 transmit phase detector polarity
// - bits 10:9 transmit VHF pump current
// - address six word loads control register
// - bits 22:21 set IF/baseband gain, digital
// - bits 20:19 select reference frequency
`timescale 1ns/100ps

module scc_regs
(
  input  wire logic        clk,             // 20 MHz clock
  input  wire logic        rst,             // Async reset, active high
  input  wire logic        word_valid,      // One-cycle strobe, word complete
  input  wire logic [23:0] word_data,       // Latched serial word
  input  wire logic        band_1900,       // 1900 MHz mode from earlier word
  input  wire logic        narrowband_mode, // Narrowband digital mode active
  output logic             uhf_in_1900,     // UHF PLL input from 1900 path
  output logic             frac_comp_en,    // Fractional-N compensation on
  output logic             doubler_en,      // UHF doubler active
  output logic      [4:0]  frac_denom,      // Fractional-N denominator
  output logic      [1:0]  uhf_cp_sel,      // UHF pump current code
  output logic             rx_low_side,     // Rx second LO low-side injection
  output logic             rx_div4,         // Rx second LO VCO/4
  output logic             rx_pd_invert,    // Rx phase detector inverted
  output logic      [1:0]  rx_cp_sel,       // Rx VHF pump current code
  output logic             tx_dll_en,       // Transmit DLL enabled
  output logic             tx_high_side,    // Tx up-converter high side
  output logic             tx_div4,         // Tx second LO VCO/4
  output logic             tx_pd_invert,    // Tx phase detector inverted
  output logic      [1:0]  tx_cp_sel,       // Tx VHF pump current code
  output logic      [4:0]  if_gain_db,      // IF gain in dB
  output logic      [2:0]  bb_gain_db,      // Baseband gain in dB
  output logic      [1:0]  reference_freq_select, // Reference code
  output logic             ref_sel_valid    // Reference code is defined
);

  // ==========================================================================
  // State
  // All block state in one struct, registered once
  typedef struct packed {
    logic [23:0] synth;    // Synthesizer setup word
    logic [23:0] ctrl;     // Control word
    logic        uhf_in;   // Output copies, each a flip-flop
    logic        frac;
    logic        dbl;
    logic [4:0]  den;
    logic [1:0]  ucp;
    logic        rxs;
    logic        rxd;
    logic        rxp;
    logic [1:0]  rxc;
    logic        dll;
    logic        txs;
    logic        txd;
    logic        txp;
    logic [1:0]  txc;
    logic [4:0]  ifg;
    logic [2:0]  bbg;
    logic [1:0]  ref_sel;
    logic        ref_ok;
  } scc_state_type;

  scc_state_type s_q;            // Registered state
  scc_state_type s_d;            // Next state
  logic [23:0]   synth_n;        // Next synthesizer word
  logic [23:0]   ctrl_n;         // Next control word
  logic [4:0]    den_w;          // Decoded denominator
  logic [4:0]    ifg_w;          // Decoded IF gain
  logic [2:0]    bbg_w;          // Decoded baseband gain
  logic [3:0]    addr_w;         // Address field of incoming word

  assign addr_w = word_data[scc_pkg::ADDR_W-1:0];

  // ==========================================================================
  // Word routing
  // A word only lands in the register whose address it carries; others hold
  always_comb
  begin
    synth_n = s_q.synth;
    ctrl_n  = s_q.ctrl;
    if (word_valid && addr_w == scc_pkg::ADDR_SYNTH)
    begin
      synth_n = word_data;
    end
    if (word_valid && addr_w == scc_pkg::ADDR_CTRL)
    begin
      ctrl_n = word_data;
    end
  end

  // Lookups driven from the next words so outputs track in the same cycle
  scc_dec u_dec
  (
    .den_sel (synth_n[scc_pkg::SY_DEN_HI:scc_pkg::SY_DEN_LO]),
    .bbg_sel (ctrl_n[scc_pkg::CT_BBG_HI:scc_pkg::CT_BBG_LO]),
    .den_val (den_w),
    .if_db   (ifg_w),
    .bb_db   (bbg_w)
  );

  // ==========================================================================
  // Field decode
  // Gated fields look at the mode inputs every cycle, so a mode change
  // takes effect without a rewrite of the word
  always_comb
  begin
    s_d         = s_q;
    s_d.synth   = synth_n;
    s_d.ctrl    = ctrl_n;
    // Bits 16 and 6 drive nothing; the host writes zero there
    s_d.dbl     = synth_n[scc_pkg::SY_DOUBLER] & band_1900;
    s_d.uhf_in  = synth_n[scc_pkg::SY_UHF_IN] & band_1900
                  & synth_n[scc_pkg::SY_DOUBLER];
    s_d.frac    = synth_n[scc_pkg::SY_FRAC_CMP];
    s_d.den     = den_w;
    s_d.ucp     = synth_n[scc_pkg::SY_UCP_HI:scc_pkg::SY_UCP_LO];
    s_d.rxs     = synth_n[scc_pkg::SY_RX_SIDE];
    s_d.rxd     = synth_n[scc_pkg::SY_RX_DIV];
    s_d.rxp     = synth_n[scc_pkg::SY_RX_POL];
    s_d.rxc     = synth_n[scc_pkg::SY_RX_CP_HI:scc_pkg::SY_RX_CP_LO];
    // Bit 15 is also listed unused; the DLL enable meaning is kept
    s_d.dll     = synth_n[scc_pkg::SY_TX_DLL];
    s_d.txs     = synth_n[scc_pkg::SY_TX_SIDE];
    s_d.txd     = synth_n[scc_pkg::SY_TX_DIV];
    s_d.txp     = synth_n[scc_pkg::SY_TX_POL];
    s_d.txc     = synth_n[scc_pkg::SY_TX_CP_HI:scc_pkg::SY_TX_CP_LO];
    // Gain applies only in narrowband digital mode; otherwise nominal pair
    if (narrowband_mode)
    begin
      s_d.ifg   = ifg_w;
      s_d.bbg   = bbg_w;
    end
    else
    begin
      s_d.ifg   = scc_pkg::IFG_11;
      s_d.bbg   = scc_pkg::BBDB_0;
    end
    s_d.ref_sel = ctrl_n[scc_pkg::CT_REF_HI:scc_pkg::CT_REF_LO];
    s_d.ref_ok  = (s_d.ref_sel == scc_pkg::REF_14M4)
                  || (s_d.ref_sel == scc_pkg::REF_19M44);
  end

  // ==========================================================================
  // State register
  // Reset loads all-zero words, denominator 5 and the nominal gain pair whatever the mode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q         <= '0;
      s_q.synth   <= scc_pkg::RST_WORD;
      s_q.ctrl    <= scc_pkg::RST_WORD;
      s_q.den     <= scc_pkg::DEN_00;
      s_q.ifg     <= scc_pkg::IFG_11;
      s_q.bbg     <= scc_pkg::BBDB_0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs, each straight from the state flip-flops
  assign uhf_in_1900           = s_q.uhf_in;
  assign frac_comp_en          = s_q.frac;
  assign doubler_en            = s_q.dbl;
  assign frac_denom            = s_q.den;
  assign uhf_cp_sel            = s_q.ucp;
  assign rx_low_side           = s_q.rxs;
  assign rx_div4               = s_q.rxd;
  assign rx_pd_invert          = s_q.rxp;
  assign rx_cp_sel             = s_q.rxc;
  assign tx_dll_en             = s_q.dll;
  assign tx_high_side          = s_q.txs;
  assign tx_div4               = s_q.txd;
  assign tx_pd_invert          = s_q.txp;
  assign tx_cp_sel             = s_q.txc;
  assign if_gain_db            = s_q.ifg;
  assign bb_gain_db            = s_q.bbg;
  assign reference_freq_select = s_q.ref_sel;
  assign ref_sel_valid         = s_q.ref_ok;

  // ==========================================================================
  // Checks
  // Each check except uhf_gate_a, which looks at the same edge as uhf_in_1900, looks one edge after the word or mode level that drives it;
  // reset cancels every attempt in flight, so no check spans a reset
  // Loading and holding of the two words
  synth_load_a: assert property (@(posedge clk) disable iff (rst)
    word_valid && addr_w == scc_pkg::ADDR_SYNTH |=> rx_div4 == $past(word_data[scc_pkg::SY_RX_DIV])
      && tx_cp_sel == $past(word_data[scc_pkg::SY_TX_CP_HI:scc_pkg::SY_TX_CP_LO]))
    else $error("synthesizer word not loaded");

  ctrl_load_a: assert property (@(posedge clk) disable iff (rst)
    word_valid && addr_w == scc_pkg::ADDR_CTRL
      |=> reference_freq_select == $past(word_data[scc_pkg::CT_REF_HI:scc_pkg::CT_REF_LO]))
    else $error("control word not loaded");

  field_hold_a: assert property (@(posedge clk) disable iff (rst)
    !(word_valid && addr_w == scc_pkg::ADDR_SYNTH) |=> $stable(rx_low_side) && $stable(tx_dll_en))
    else $error("synthesizer field changed without write");

  ctrl_hold_a: assert property (@(posedge clk) disable iff (rst)
    !(word_valid && addr_w == scc_pkg::ADDR_CTRL) |=> $stable(reference_freq_select))
    else $error("control field changed without write");

  // Mode gating of the UHF doubler and input band
  uhf_gate_a: assert property (@(posedge clk) disable iff (rst)
    uhf_in_1900 |-> doubler_en && $past(band_1900))
    else $error("UHF input selected without doubler");

  doubler_gate_a: assert property (@(posedge clk) disable iff (rst)
    !band_1900 |=> !doubler_en)
    else $error("doubler active outside 1900 mode");

  doubler_on_a: assert property (@(posedge clk) disable iff (rst)
    band_1900 && word_valid && addr_w == scc_pkg::ADDR_SYNTH && word_data[scc_pkg::SY_DOUBLER]
      |=> doubler_en)
    else $error("doubler not enabled in 1900 mode");

  // UHF synthesizer fields
  frac_bit_a: assert property (@(posedge clk) disable iff (rst)
    word_valid && addr_w == scc_pkg::ADDR_SYNTH |=> frac_comp_en == $past(word_data[scc_pkg::SY_FRAC_CMP]))
    else $error("fractional compensation bit not followed");

  denom_map_a: assert property (@(posedge clk) disable iff (rst)
    word_valid && addr_w == scc_pkg::ADDR_SYNTH && word_data[scc_pkg::SY_DEN_HI:scc_pkg::SY_DEN_LO] == 2'h2
      |=> frac_denom == scc_pkg::DEN_10)
    else $error("denominator code 10 not 13");

  denom_top_a: assert property (@(posedge clk) disable iff (rst)
    word_valid && addr_w == scc_pkg::ADDR_SYNTH && word_data[scc_pkg::SY_DEN_HI:scc_pkg::SY_DEN_LO] == 2'h3
      |=> frac_denom == scc_pkg::DEN_11)
    else $error("denominator code 11 not 20");

  uhf_pump_a: assert property (@(posedge clk) disable iff (rst)
    word_valid && addr_w == scc_pkg::ADDR_SYNTH
      |=> uhf_cp_sel == $past(word_data[scc_pkg::SY_UCP_HI:scc_pkg::SY_UCP_LO]))
    else $error("UHF pump current code not followed");

  // Receive LO fields
  rx_side_a: assert property (@(posedge clk) disable iff (rst)
    word_valid && addr_w == scc_pkg::ADDR_SYNTH
      |=> rx_low_side == $past(word_data[scc_pkg::SY_RX_SIDE]))
    else $error("receive injection side not followed");

  rx_polarity_a: assert property (@(posedge clk) disable iff (rst)
    word_valid && addr_w == scc_pkg::ADDR_SYNTH
      |=> rx_pd_invert == $past(word_data[scc_pkg::SY_RX_POL]))
    else $error("receive detector polarity not followed");

  rx_pump_a: assert property (@(posedge clk) disable iff (rst)
    word_valid && addr_w == scc_pkg::ADDR_SYNTH
      |=> rx_cp_sel == $past(word_data[scc_pkg::SY_RX_CP_HI:scc_pkg::SY_RX_CP_LO]))
    else $error("receive pump current code not followed");

  // Transmit LO fields
  tx_dll_a: assert property (@(posedge clk) disable iff (rst)
    word_valid && addr_w == scc_pkg::ADDR_SYNTH
      |=> tx_dll_en == $past(word_data[scc_pkg::SY_TX_DLL]))
    else $error("transmit DLL enable not followed");

  tx_side_a: assert property (@(posedge clk) disable iff (rst)
    word_valid && addr_w == scc_pkg::ADDR_SYNTH
      |=> tx_high_side == $past(word_data[scc_pkg::SY_TX_SIDE]))
    else $error("transmit injection side not followed");

  tx_divide_a: assert property (@(posedge clk) disable iff (rst)
    word_valid && addr_w == scc_pkg::ADDR_SYNTH
      |=> tx_div4 == $past(word_data[scc_pkg::SY_TX_DIV]))
    else $error("transmit LO divide not followed");

  tx_polarity_a: assert property (@(posedge clk) disable iff (rst)
    word_valid && addr_w == scc_pkg::ADDR_SYNTH
      |=> tx_pd_invert == $past(word_data[scc_pkg::SY_TX_POL]))
    else $error("transmit detector polarity not followed");

  // Gain pair and reference code
  gain_map_a: assert property (@(posedge clk) disable iff (rst)
    narrowband_mode && word_valid && addr_w == scc_pkg::ADDR_CTRL && word_data[scc_pkg::CT_BBG_HI:scc_pkg::CT_BBG_LO] == 2'h0
      |=> if_gain_db == scc_pkg::IFG_00 && bb_gain_db == scc_pkg::BBDB_6)
    else $error("gain pair wrong for code 00");

  gain_nominal_a: assert property (@(posedge clk) disable iff (rst)
    !narrowband_mode |=> if_gain_db == scc_pkg::IFG_11 && bb_gain_db == scc_pkg::BBDB_0)
    else $error("gain pair not nominal outside narrowband mode");

  ref_valid_a: assert property (@(posedge clk) disable iff (rst)
    word_valid && addr_w == scc_pkg::ADDR_CTRL
      |=> ref_sel_valid == ($past(word_data[scc_pkg::CT_REF_HI:scc_pkg::CT_REF_LO]) == scc_pkg::REF_14M4
      || $past(word_data[scc_pkg::CT_REF_HI:scc_pkg::CT_REF_LO]) == scc_pkg::REF_19M44))
    else $error("reference code validity wrong");

endmodule

/* File: core/scc_pkg.sv */
// Package for the synthesizer and control configuration registers.
// Assumes a single 20 MHz clock domain; used by every core file.
package scc_pkg;

  // ==========================================================================
  // Word layout
  localparam int unsigned WORD_W      = 24;   // Serial word width
  localparam int unsigned ADDR_W      = 4;    // Address field width
  localparam logic [3:0]  ADDR_SYNTH  = 4'h5; // Synthesizer setup address
  localparam logic [3:0]  ADDR_CTRL   = 4'h6; // Receive/transmit control address

  // ==========================================================================
  // Synthesizer field positions
  localparam int unsigned SY_UHF_IN   = 23;   // UHF PLL input band
  localparam int unsigned SY_RX_SIDE  = 22;   // Rx second LO injection side
  localparam int unsigned SY_RX_DIV   = 21;   // Rx second LO divide
  localparam int unsigned SY_RX_POL   = 20;   // Rx phase detector polarity
  localparam int unsigned SY_RX_CP_HI = 19;   // Rx VHF pump current msb
  localparam int unsigned SY_RX_CP_LO = 18;   // Rx VHF pump current lsb
  localparam int unsigned SY_FRAC_CMP = 17;   // Fractional-N compensation
  localparam int unsigned SY_TX_DLL   = 15;   // Transmit DLL enable
  localparam int unsigned SY_DOUBLER  = 14;   // UHF doubler
  localparam int unsigned SY_TX_SIDE  = 13;   // Tx up-converter injection side
  localparam int unsigned SY_TX_DIV   = 12;   // Tx second LO divide
  localparam int unsigned SY_TX_POL   = 11;   // Tx phase detector polarity
  localparam int unsigned SY_TX_CP_HI = 10;   // Tx VHF pump current msb
  localparam int unsigned SY_TX_CP_LO = 9;    // Tx VHF pump current lsb
  localparam int unsigned SY_DEN_HI   = 8;    // Denominator select msb
  localparam int unsigned SY_DEN_LO   = 7;    // Denominator select lsb
  localparam int unsigned SY_UCP_HI   = 5;    // UHF pump current msb
  localparam int unsigned SY_UCP_LO   = 4;    // UHF pump current lsb

  // ==========================================================================
  // Control field positions
  localparam int unsigned CT_BBG_HI   = 22;   // Baseband gain select msb
  localparam int unsigned CT_BBG_LO   = 21;   // Baseband gain select lsb
  localparam int unsigned CT_REF_HI   = 20;   // Reference select msb
  localparam int unsigned CT_REF_LO   = 19;   // Reference select lsb

  // ==========================================================================
  // Encodings and reset values
  localparam logic [4:0]  DEN_00      = 5'h05; // Denominator 5
  localparam logic [4:0]  DEN_01      = 5'h08; // Denominator 8
  localparam logic [4:0]  DEN_10      = 5'h0D; // Denominator 13
  localparam logic [4:0]  DEN_11      = 5'h14; // Denominator 20
  localparam logic [4:0]  IFG_00      = 5'h0E; // IF gain 14 dB
  localparam logic [4:0]  IFG_01      = 5'h11; // IF gain 17 dB
  localparam logic [4:0]  IFG_10      = 5'h11; // IF gain 17 dB
  localparam logic [4:0]  IFG_11      = 5'h14; // IF gain 20 dB
  localparam logic [2:0]  BBDB_6      = 3'h6;  // Baseband gain 6 dB
  localparam logic [2:0]  BBDB_0      = 3'h0;  // Baseband gain 0 dB
  localparam logic [1:0]  REF_14M4    = 2'h1;  // 14.4 MHz reference code
  localparam logic [1:0]  REF_19M44   = 2'h2;  // 19.44 MHz reference code
  localparam logic [23:0] RST_WORD    = 24'h000000; // Word value after reset

endpackage

/* File: core/scc_dec.sv */
// Decoder for the two-bit lookups of the configuration words.
// Assumes purely combinational use by scc_regs on the same clock.
`timescale 1ns/100ps

module scc_dec
(
  input  wire logic [1:0] den_sel,   // Fractional-N denominator code
  input  wire logic [1:0] bbg_sel,   // Baseband gain select code
  output logic      [4:0] den_val,   // Denominator value
  output logic      [4:0] if_db,     // IF gain in dB
  output logic      [2:0] bb_db      // Baseband gain in dB
);

  // ==========================================================================
  // Lookup tables
  // Denominator table
  always_comb
  begin
    unique case (den_sel)
      2'h0: den_val = scc_pkg::DEN_00;
      2'h1: den_val = scc_pkg::DEN_01;
      2'h2: den_val = scc_pkg::DEN_10;
      2'h3: den_val = scc_pkg::DEN_11;
    endcase
  end

  // IF and baseband gain pair move together
  always_comb
  begin
    unique case (bbg_sel)
      2'h0:
      begin
        if_db = scc_pkg::IFG_00;
        bb_db = scc_pkg::BBDB_6;
      end
      2'h1:
      begin
        if_db = scc_pkg::IFG_01;
        bb_db = scc_pkg::BBDB_6;
      end
      2'h2:
      begin
        if_db = scc_pkg::IFG_10;
        bb_db = scc_pkg::BBDB_0;
      end
      2'h3:
      begin
        if_db = scc_pkg::IFG_11;
        bb_db = scc_pkg::BBDB_0;
      end
    endcase
  end

endmodule

/* File: tb/scc_host_model.sv */
// Host model: presents whole configuration words to scc_regs.
// Assumes the bench calls send and idle from one thread on clk.
`timescale 1ns/100ps
module scc_host_model
(
  input  wire logic        clk,        // System clock
  output logic             word_valid, // Word strobe
  output logic      [23:0] word_data   // Word bits
);
  // ==========================================================================
  // Word driver
  initial
  begin
    word_valid = 1'b0;
    word_data  = 24'h000000;
  end

  // Present one word; back-to-back calls keep the strobe high
  task automatic send(input logic [23:0] w);
  begin
    @(posedge clk);
    word_valid <= 1'b1;
    // Unused synthesizer bits go out as zero
    word_data  <= (w[3:0] == 4'h5) ? (w & 24'hFEFFBF) : w;
  end
  endtask

  // Drop the strobe; data flips so stale bits never look like a word
  task automatic idle();
  begin
    @(posedge clk);
    word_valid <= 1'b0;
    word_data  <= ~word_data;
  end
  endtask
endmodule

/* File: tb/scc_regs_test.sv */
// Self-checking bench for scc_regs with a host word model.
// Assumes one 20 MHz clock; mode inputs are driven here directly.
`timescale 1ns/100ps
module scc_regs_test;
  // ==========================================================================
  // Signals
  logic        clk;                   // Clock
  logic        rst;                   // Reset
  logic        band_1900;             // 1900 MHz mode
  logic        narrowband_mode;       // Digital mode
  wire         word_valid;            // From host model
  wire  [23:0] word_data;             // From host model
  logic        uhf_in_1900, frac_comp_en, doubler_en, rx_low_side, rx_div4;
  logic        rx_pd_invert, tx_dll_en, tx_high_side, tx_div4, tx_pd_invert;
  logic        ref_sel_valid;         // Reference code defined
  logic [4:0]  frac_denom, if_gain_db;
  logic [2:0]  bb_gain_db;            // Baseband gain
  logic [1:0]  uhf_cp_sel, rx_cp_sel, tx_cp_sel, reference_freq_select;
  int          errors;                // Mismatches
  int          checks_done;           // Comparisons
  logic [23:0] sy_e, ct_e, w;         // Shadow words and scratch
  logic [15:0] seed;                  // Random state

  scc_host_model i_scc_host_model (.clk(clk), .word_valid(word_valid), .word_data(word_data));

  scc_regs i_scc_regs (.clk(clk), .rst(rst), .word_valid(word_valid), .word_data(word_data),
    .band_1900(band_1900), .narrowband_mode(narrowband_mode), .uhf_in_1900(uhf_in_1900),
    .frac_comp_en(frac_comp_en), .doubler_en(doubler_en), .frac_denom(frac_denom),
    .uhf_cp_sel(uhf_cp_sel), .rx_low_side(rx_low_side), .rx_div4(rx_div4),
    .rx_pd_invert(rx_pd_invert), .rx_cp_sel(rx_cp_sel), .tx_dll_en(tx_dll_en),
    .tx_high_side(tx_high_side), .tx_div4(tx_div4), .tx_pd_invert(tx_pd_invert),
    .tx_cp_sel(tx_cp_sel), .if_gain_db(if_gain_db), .bb_gain_db(bb_gain_db),
    .reference_freq_select(reference_freq_select), .ref_sel_valid(ref_sel_valid));

  // ==========================================================================
  // Clock and watchdog
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // Run needs well under 2000 cycles; 5000 means a hang
  initial
  begin
    #250000;
    errors++;
    tally_and_finish();
  end

  // ==========================================================================
  // Expectation helpers
  function automatic logic [23:0] rnd();
    repeat (24) seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return {seed, seed[7:0]};
  endfunction

  function automatic logic [4:0] den_of(input logic [1:0] c);
    case (c)
      2'h0: return 5'h05;
      2'h1: return 5'h08;
      2'h2: return 5'h0D;
      default: return 5'h14;
    endcase
  endfunction

  // IF gain in the upper five bits, baseband gain in the lower three
  function automatic logic [7:0] gain_of(input logic [1:0] c, input logic nb);
    if (nb !== 1'b1)
      return {5'h14, 3'h0};
    case (c)
      2'h0: return {5'h0E, 3'h6};
      2'h1: return {5'h11, 3'h6};
      2'h2: return {5'h11, 3'h0};
      default: return {5'h14, 3'h0};
    endcase
  endfunction

  // ==========================================================================
  // Drive and compare tasks
  task automatic put(input logic [23:0] v);
    i_scc_host_model.send(v);
    if (v[3:0] == 4'h5)
      sy_e = v & 24'hFEFFBF;
    if (v[3:0] == 4'h6)
      ct_e = v;
  endtask

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_all();
    #1;
    cmp("uhf_in_1900", 8'(sy_e[23] & sy_e[14] & band_1900), 8'(uhf_in_1900));
    cmp("doubler_en", 8'(sy_e[14] & band_1900), 8'(doubler_en));
    cmp("uhf_setup", 8'({sy_e[17], sy_e[5:4]}), 8'({frac_comp_en, uhf_cp_sel}));
    cmp("frac_denom", 8'(den_of(sy_e[8:7])), 8'(frac_denom));
    cmp("rx_setup", 8'(sy_e[22:18]), 8'({rx_low_side, rx_div4, rx_pd_invert, rx_cp_sel}));
    cmp("tx_setup", 8'({sy_e[15], sy_e[13:9]}),
        8'({tx_dll_en, tx_high_side, tx_div4, tx_pd_invert, tx_cp_sel}));
    cmp("gains", gain_of(ct_e[22:21], narrowband_mode), {if_gain_db, bb_gain_db});
    cmp("ref_select", 8'(ct_e[20:19]), 8'(reference_freq_select));
    cmp("ref_valid", 8'(ct_e[20] ^ ct_e[19]), 8'(ref_sel_valid));
    // Back on a rising edge so mode and reset writes that follow land there
    @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  initial
  begin
    errors = 0;
    checks_done = 0;
    seed = 16'd31094;
    sy_e = 24'h000000;
    ct_e = 24'h000000;
    rst = 1'b1;
    band_1900 = 1'b0;
    narrowband_mode = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check_all();
    $display("test reset_values done");
    // Every two-bit code, synthesizer and control words back to back
    band_1900 <= 1'b1;
    narrowband_mode <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      w = rnd();
      w[8:7] = 2'(i);
      w[5:4] = 2'(i);
      w[19:18] = 2'(i);
      w[10:9] = 2'(i);
      w[3:0] = 4'h5;
      put(w);
      w = rnd();
      w[22:21] = 2'(i);
      w[20:19] = 2'(i);
      w[3:0] = 4'h6;
      put(w);
      i_scc_host_model.idle();
      check_all();
    end
    $display("test code_tables done");
    // Mode inputs gate doubler, input band and gains
    put(24'h80C005 | rnd() & 24'h00F000);
    // Gain code 00 so the narrowband gating shows a pair unlike the nominal one
    put(24'h000006 | rnd() & 24'h9FFFF0);
    i_scc_host_model.idle();
    for (int m = 0; m < 4; m++)
    begin
      band_1900 <= m[0];
      narrowband_mode <= m[1];
      repeat (2) @(posedge clk);
      check_all();
    end
    $display("test mode_gating done");
    // Random pairs, foreign addresses must leave both registers alone
    for (int k = 0; k < 80; k++)
    begin
      w = rnd();
      band_1900 <= w[23];
      narrowband_mode <= w[22];
      for (int j = 0; j < 2; j++)
      begin
        w = rnd();
        if (w[5:4] == 2'h0)
          w[3:0] = 4'h5;
        else if (w[5:4] == 2'h1)
          w[3:0] = 4'h6;
        else if (w[3:1] == 3'h3 || w[3:0] == 4'h5)
          w[3:0] = 4'hA;
        put(w);
      end
      i_scc_host_model.idle();
      @(posedge clk);
      check_all();
    end
    $display("test random_words done");
    // Reset in mid-run clears both registers
    narrowband_mode <= 1'b0;
    rst <= 1'b1;
    sy_e = 24'h000000;
    ct_e = 24'h000000;
    repeat (2) @(posedge clk);
    check_all();
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check_all();
    $display("test mid_reset done");
    tally_and_finish();
  end
endmodule
